// ==== lscr_pkg.sv ====
// Package with the register map, field layout, reset values and current scaling constants.
package lscr_pkg;

	// Byte addresses of the registers on the serial register port.
	localparam logic [7:0] ADDR_OFFICE_DIM = 8'h0C;
	localparam logic [7:0] ADDR_DARK_MAX = 8'h0D;
	localparam logic [7:0] ADDR_DARK_DIM = 8'h0E;
	localparam logic [7:0] ADDR_FADE_LAW = 8'h0F;
	localparam logic [7:0] ADDR_SINK_EN = 8'h10;

	// Field widths and positions.
	localparam int CODE_W = 7;
	localparam int LAW_W = 2;
	localparam int SINK_N = 7;
	localparam int CUR_W = 15;
	localparam int SINK_ONE_BIT = 0;
	localparam int SINK_TWO_BIT = 1;
	localparam int SINK_THREE_BIT = 2;
	localparam int SINK_FOUR_BIT = 3;
	localparam int SINK_FIVE_BIT = 4;
	localparam int SINK_SIX_BIT = 5;
	localparam int SINK_SEVEN_BIT = 6;

	// Reset values of the stored fields.
	localparam logic [6:0] RST_CODE = 7'h00;
	localparam logic [1:0] RST_LAW = 2'h0;
	localparam logic [6:0] RST_SINK_EN = 7'h00;
	localparam logic [7:0] RDATA_NONE = 8'h00;

	// Current scaling in microamps: 0.236 mA per linear step, 30 mA full scale.
	localparam logic [6:0] CODE_MAX = 7'h7F;
	localparam logic [14:0] LIN_STEP_UA = 15'h00EC;
	localparam logic [14:0] FULL_SCALE_UA = 15'h7530;
	localparam logic [29:0] SQ_DENOM = 30'h00003F01;
	localparam logic [29:0] SQ_ROUND = 30'h00001F80;

	// Fade transfer laws of the independent sinks.
	typedef enum logic [1:0] {
		LAW_LIN_LIN,
		LAW_SQ_LIN,
		LAW_SQ_CUBIC_A,
		LAW_SQ_CUBIC_B
	} lscr_law_t;

endpackage

// ==== lscr_code_if.sv ====
// Interface carrying a current code and its law to the mapper and the current back.
`timescale 1ns/10ps
`default_nettype none
interface lscr_code_if;
	logic [6:0] code; // Selected 7-bit current code.
	logic square; // High selects the square law, low the linear law.
	logic [14:0] current_ua; // Resulting sink current in microamps.
	modport sel (output code, output square);
	modport map (input code, input square, output current_ua);
endinterface
`default_nettype wire

// ==== lscr_code_map.sv ====
// Combinational map from a 7-bit current code to a current in microamps.
`timescale 1ns/10ps
`default_nettype none
module lscr_code_map (
	lscr_code_if.map cif
);
	import lscr_pkg::*;

	logic [29:0] sq_prod; // Code squared times full scale.
	logic [29:0] sq_quot; // Rounded quotient for the square law.

	// Linear law adds one step per code; the top code is pinned to full scale.
	// Square law scales full scale by the code squared over the top code squared.
	always_comb begin
		sq_prod = 30'({23'h0, cif.code} * {23'h0, cif.code}) * 30'(FULL_SCALE_UA);
		sq_quot = (sq_prod + SQ_ROUND) / SQ_DENOM;
		if (cif.code == CODE_MAX) begin
			cif.current_ua = FULL_SCALE_UA;
		end else if (cif.square) begin
			cif.current_ua = sq_quot[14:0];
		end else begin
			cif.current_ua = 15'({8'h0, cif.code} * LIN_STEP_UA);
		end
	end
endmodule
`default_nettype wire

// ==== lscr_level_sel.sv ====
// Picks the backlight code of the active level, dim or maximum.
`timescale 1ns/10ps
`default_nettype none
module lscr_level_sel (
	input wire logic dark_i,
	input wire logic dim_i,
	input wire logic square_i,
	input wire logic [6:0] office_max_i,
	input wire logic [6:0] office_dim_i,
	input wire logic [6:0] dark_max_i,
	input wire logic [6:0] dark_dim_i,
	lscr_code_if.sel cif
);
	// Dim timeout or the user dim flag moves the active level to its dim code.
	always_comb begin
		cif.square = square_i;
		if (dark_i) begin
			cif.code = dim_i ? dark_dim_i : dark_max_i;
		end else begin
			cif.code = dim_i ? office_dim_i : office_max_i;
		end
	end
endmodule
`default_nettype wire

// ==== lscr_top.sv ====
// Register bank for backlight dim codes and the dark maximum code, sink fade law and sink enables.
`timescale 1ns/10ps
`default_nettype none
module lscr_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic dark_level_i,
	input wire logic dim_timeout_i,
	input wire logic dim_en_i,
	input wire logic backlight_square_i,
	input wire logic [lscr_pkg::CODE_W-1:0] office_max_code_i,
	output logic [lscr_pkg::CODE_W-1:0] office_dim_code_o,
	output logic [lscr_pkg::CODE_W-1:0] dark_max_code_o,
	output logic [lscr_pkg::CODE_W-1:0] dark_dim_code_o,
	output logic [lscr_pkg::LAW_W-1:0] sink_fade_law_select_o,
	output logic fade_square_o,
	output logic fade_cubic_o,
	output logic sink_one_on_o,
	output logic sink_two_on_o,
	output logic sink_three_on_o,
	output logic sink_four_on_o,
	output logic sink_five_on_o,
	output logic sink_six_on_o,
	output logic sink_seven_on_o,
	output logic [lscr_pkg::CODE_W-1:0] backlight_code_o,
	output logic [lscr_pkg::CUR_W-1:0] backlight_current_ua_o
);
	import lscr_pkg::*;

	// Stored fields; reserved bits are never stored.
	logic [6:0] office_dim_current; // Office dim code.
	logic [6:0] dark_max_current; // Dark maximum code.
	logic [6:0] dark_dim_current; // Dark dim code.
	logic [1:0] sink_fade_law; // Sink fade law selection.
	logic [6:0] sink_enable_mask; // One enable per independent sink.
	logic [7:0] next_rdata; // Read data before the output flop.
	lscr_law_t law_now; // Fade law as an enumerated value.

	lscr_code_if bl_if ();

	// Elaboration check that the field layout matches the logic.
	if (CODE_W != 7 || LAW_W != 2 || SINK_N != 7 || CUR_W != 15) begin : g_chk
		$error("lscr_top supports only the fixed 7-bit code layout.");
	end

	// Office dim code register; bit 7 of the write is dropped.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			office_dim_current <= RST_CODE;
		end else if (reg_wr_i && reg_addr_i == ADDR_OFFICE_DIM) begin
			office_dim_current <= reg_wdata_i[6:0];
		end
	end

	// Dark maximum code register.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dark_max_current <= RST_CODE;
		end else if (reg_wr_i && reg_addr_i == ADDR_DARK_MAX) begin
			dark_max_current <= reg_wdata_i[6:0];
		end
	end

	// Dark dim code register.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dark_dim_current <= RST_CODE;
		end else if (reg_wr_i && reg_addr_i == ADDR_DARK_DIM) begin
			dark_dim_current <= reg_wdata_i[6:0];
		end
	end

	// Fade law register; bits 7..2 are dropped.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sink_fade_law <= RST_LAW;
		end else if (reg_wr_i && reg_addr_i == ADDR_FADE_LAW) begin
			sink_fade_law <= reg_wdata_i[1:0];
		end
	end

	// Sink enable register; bit 7 is dropped.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sink_enable_mask <= RST_SINK_EN;
		end else if (reg_wr_i && reg_addr_i == ADDR_SINK_EN) begin
			sink_enable_mask <= reg_wdata_i[6:0];
		end
	end

	// Read mux; reserved bits and unmapped addresses read as zero.
	always_comb begin
		next_rdata = RDATA_NONE;
		unique case (reg_addr_i)
			ADDR_OFFICE_DIM: next_rdata = {1'b0, office_dim_current};
			ADDR_DARK_MAX: next_rdata = {1'b0, dark_max_current};
			ADDR_DARK_DIM: next_rdata = {1'b0, dark_dim_current};
			ADDR_FADE_LAW: next_rdata = {6'h00, sink_fade_law};
			ADDR_SINK_EN: next_rdata = {1'b0, sink_enable_mask};
			default: next_rdata = RDATA_NONE;
		endcase
	end

	// Read data flop; it holds between reads.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= RDATA_NONE;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

	// Fade law cast to its enumerated value for the decode flops below.
	always_comb begin
		law_now = lscr_law_t'(sink_fade_law);
	end

	// Law decode flops; every code but the first uses the square law DAC.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fade_square_o <= 1'b0;
			fade_cubic_o <= 1'b0;
		end else begin
			unique case (law_now)
				LAW_LIN_LIN: begin
					fade_square_o <= 1'b0;
					fade_cubic_o <= 1'b0;
				end
				LAW_SQ_LIN: begin
					fade_square_o <= 1'b1;
					fade_cubic_o <= 1'b0;
				end
				LAW_SQ_CUBIC_A, LAW_SQ_CUBIC_B: begin
					fade_square_o <= 1'b1;
					fade_cubic_o <= 1'b1;
				end
			endcase
		end
	end

	// Stored fields are flops and go straight out.
	assign office_dim_code_o = office_dim_current;
	assign dark_max_code_o = dark_max_current;
	assign dark_dim_code_o = dark_dim_current;
	assign sink_fade_law_select_o = sink_fade_law;
	assign sink_one_on_o = sink_enable_mask[SINK_ONE_BIT];
	assign sink_two_on_o = sink_enable_mask[SINK_TWO_BIT];
	assign sink_three_on_o = sink_enable_mask[SINK_THREE_BIT];
	assign sink_four_on_o = sink_enable_mask[SINK_FOUR_BIT];
	assign sink_five_on_o = sink_enable_mask[SINK_FIVE_BIT];
	assign sink_six_on_o = sink_enable_mask[SINK_SIX_BIT];
	assign sink_seven_on_o = sink_enable_mask[SINK_SEVEN_BIT];

	// Level selection picks the dim code when dimming is due.
	lscr_level_sel u_sel (
		.dark_i(dark_level_i),
		.dim_i(dim_timeout_i | dim_en_i),
		.square_i(backlight_square_i),
		.office_max_i(office_max_code_i),
		.office_dim_i(office_dim_current),
		.dark_max_i(dark_max_current),
		.dark_dim_i(dark_dim_current),
		.cif(bl_if)
	);

	// Current mapping of the selected code.
	lscr_code_map u_map (
		.cif(bl_if)
	);

	// Backlight code and current are registered before leaving the block.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			backlight_code_o <= RST_CODE;
			backlight_current_ua_o <= 15'h0000;
		end else begin
			backlight_code_o <= bl_if.code;
			backlight_current_ua_o <= bl_if.current_ua;
		end
	end

	// A register write to a given address.
	sequence s_wr(logic [7:0] a);
		reg_wr_i && reg_addr_i == a;
	endsequence

	// A register read to a given address.
	sequence s_rd(logic [7:0] a);
		reg_rd_i && reg_addr_i == a;
	endsequence

	property p_office_store;
		@(posedge clk_i) disable iff (rst_i)
		s_wr(ADDR_OFFICE_DIM) |=> office_dim_code_o == $past(reg_wdata_i[6:0]);
	endproperty
	a_office_store: assert property (p_office_store) else $error("Office dim code not stored.");

	property p_dim_select;
		@(posedge clk_i) disable iff (rst_i)
		(dim_timeout_i || dim_en_i) ##1 1'b1 |->
			backlight_code_o == ($past(dark_level_i) ? $past(dark_dim_code_o)
				: $past(office_dim_code_o));
	endproperty
	a_dim_select: assert property (p_dim_select) else $error("Dim code not selected.");

	property p_max_select;
		@(posedge clk_i) disable iff (rst_i)
		(!dim_timeout_i && !dim_en_i && dark_level_i) |=>
			backlight_code_o == $past(dark_max_code_o);
	endproperty
	a_max_select: assert property (p_max_select) else $error("Dark max code not selected.");

	property p_dark_max_store;
		@(posedge clk_i) disable iff (rst_i)
		s_wr(ADDR_DARK_MAX) |=> dark_max_code_o == $past(reg_wdata_i[6:0]);
	endproperty
	a_dark_max_store: assert property (p_dark_max_store) else $error("Dark max not stored.");

	property p_dark_dim_store;
		@(posedge clk_i) disable iff (rst_i)
		s_wr(ADDR_DARK_DIM) |=> dark_dim_code_o == $past(reg_wdata_i[6:0]);
	endproperty
	a_dark_dim_store: assert property (p_dark_dim_store) else $error("Dark dim not stored.");

	property p_current_map;
		@(posedge clk_i) disable iff (rst_i)
		(bl_if.code == 7'h00 |=> backlight_current_ua_o == 15'h0000) and
		(bl_if.code == CODE_MAX |=> backlight_current_ua_o == FULL_SCALE_UA) and
		(bl_if.code == 7'h01 && bl_if.square |=> backlight_current_ua_o == 15'h0002) and
		(bl_if.code == 7'h01 && !bl_if.square |=> backlight_current_ua_o == LIN_STEP_UA);
	endproperty
	a_current_map: assert property (p_current_map) else $error("Code to current map wrong.");

	property p_law_store;
		@(posedge clk_i) disable iff (rst_i)
		s_wr(ADDR_FADE_LAW) |=> sink_fade_law_select_o == $past(reg_wdata_i[1:0]);
	endproperty
	a_law_store: assert property (p_law_store) else $error("Fade law not stored.");

	property p_law_decode;
		@(posedge clk_i) disable iff (rst_i)
		s_wr(ADDR_FADE_LAW) ##1 !reg_wr_i |=>
			fade_square_o == ($past(reg_wdata_i[1:0], 2) != 2'h0) &&
			fade_cubic_o == $past(reg_wdata_i[1], 2);
	endproperty
	a_law_decode: assert property (p_law_decode) else $error("Fade law decode wrong.");

	property p_sink_seven;
		@(posedge clk_i) disable iff (rst_i)
		s_wr(ADDR_SINK_EN) |=> sink_seven_on_o == $past(reg_wdata_i[6]);
	endproperty
	a_sink_seven: assert property (p_sink_seven) else $error("Sink seven enable wrong.");

	property p_sink_six_five;
		@(posedge clk_i) disable iff (rst_i)
		s_wr(ADDR_SINK_EN) |=> sink_six_on_o == $past(reg_wdata_i[5]) &&
			sink_five_on_o == $past(reg_wdata_i[4]);
	endproperty
	a_sink_six_five: assert property (p_sink_six_five) else $error("Sink six or five wrong.");

	property p_sink_low;
		@(posedge clk_i) disable iff (rst_i)
		s_wr(ADDR_SINK_EN) |=> {sink_four_on_o, sink_three_on_o, sink_two_on_o,
			sink_one_on_o} == $past(reg_wdata_i[3:0]);
	endproperty
	a_sink_low: assert property (p_sink_low) else $error("Sinks four to one wrong.");

	property p_reserved_zero;
		@(posedge clk_i) disable iff (rst_i)
		(s_rd(ADDR_OFFICE_DIM) or s_rd(ADDR_DARK_MAX) or s_rd(ADDR_SINK_EN) |=>
			reg_rdata_o[7] == 1'b0) and
		(s_rd(ADDR_FADE_LAW) |=> reg_rdata_o[7:2] == 6'h00) and
		(s_rd(8'h11) |=> reg_rdata_o == RDATA_NONE);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits not zero.");

endmodule
`default_nettype wire

// ==== lscr_host_model.sv ====
// Host controller model that issues byte writes and reads on the register port.
`timescale 1ns/10ps
`default_nettype none
module lscr_host_model (
	input wire logic clk_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	// Strobes rest low until the first access.
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end

	// One write; strobe, address and data stand across the edge that takes them.
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_i);
		reg_wr_o <= 1'b1;
		reg_addr_o <= addr;
		reg_wdata_o <= data;
		@(posedge clk_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~data;
		#1;
	endtask

	// One read; the data is taken once the edge that took the strobe has settled.
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_i);
		reg_rd_o <= 1'b1;
		reg_addr_o <= addr;
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		#1;
		data = reg_rdata_i;
	endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench of the sink current register bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
	$display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_top;
	import lscr_pkg::*;
	logic clk_i, rst_i, reg_wr, reg_rd; // Clock, reset and strobes.
	logic [7:0] reg_addr, reg_wdata, rv; // Port address, data and last read value.
	wire logic [7:0] reg_rdata; // Read data of the bank.
	logic dark_level, dim_timeout, dim_en, bl_square; // Level select inputs.
	logic [6:0] office_max; // Office maximum code from outside.
	logic [6:0] office_dim, dark_max, dark_dim, bl_code; // Stored and selected codes.
	logic [1:0] law; // Stored fade law.
	logic fade_sq, fade_cu; // Decoded fade law.
	wire logic [6:0] sinks; // Sink enables, sink one in bit 0.
	logic [14:0] bl_ua; // Backlight current.
	int n_errors, checks; // Mismatch and comparison counts.
	logic [7:0] addrs [5] = '{ADDR_OFFICE_DIM, ADDR_DARK_MAX, ADDR_DARK_DIM, ADDR_FADE_LAW,
		ADDR_SINK_EN}; // Mapped addresses.
	logic [3:0] sel [6] = '{4'h0, 4'h5, 4'h8, 4'hB, 4'hC, 4'h4}; // Dark, timeout, dim flag, square.
	logic [6:0] exc [6] = '{7'h02, 7'h01, 7'h7F, 7'h03, 7'h03, 7'h01}; // Expected chosen code.

	lscr_host_model u_lscr_host_model (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
	lscr_top u_lscr_top (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
		.dark_level_i(dark_level), .dim_timeout_i(dim_timeout), .dim_en_i(dim_en),
		.backlight_square_i(bl_square), .office_max_code_i(office_max),
		.office_dim_code_o(office_dim), .dark_max_code_o(dark_max), .dark_dim_code_o(dark_dim),
		.sink_fade_law_select_o(law), .fade_square_o(fade_sq), .fade_cubic_o(fade_cu),
		.sink_one_on_o(sinks[0]), .sink_two_on_o(sinks[1]), .sink_three_on_o(sinks[2]),
		.sink_four_on_o(sinks[3]), .sink_five_on_o(sinks[4]), .sink_six_on_o(sinks[5]),
		.sink_seven_on_o(sinks[6]), .backlight_code_o(bl_code), .backlight_current_ua_o(bl_ua));

	// Free-running 100 MHz clock.
	always #5 clk_i = ~clk_i;

	// Expected current in microamps, worked out from the scaling figures.
	function automatic logic [14:0] ua(input logic [6:0] c, input logic sq);
		int v;
		if (c == 7'h7F) v = 30000;
		else if (sq) v = (30000 * c * c + 8064) / 16129;
		else v = c * 236;
		return 15'(v);
	endfunction

	// Reads one register and compares it.
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		u_lscr_host_model.rd(addr, rv);
		`CHK(rv, exp)
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{dark_level, dim_timeout, dim_en, bl_square} = 4'h0;
		office_max = 7'h02;
		n_errors = 0;
		checks = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) rd_chk(addrs[i], 8'h00);
		$display("test reset values done");
		u_lscr_host_model.wr(ADDR_OFFICE_DIM, 8'hFF);
		u_lscr_host_model.wr(ADDR_DARK_MAX, 8'hAA);
		u_lscr_host_model.wr(ADDR_DARK_DIM, 8'hD5);
		`CHK({office_dim, dark_max, dark_dim}, {7'h7F, 7'h2A, 7'h55})
		rd_chk(ADDR_OFFICE_DIM, 8'h7F);
		rd_chk(ADDR_DARK_MAX, 8'h2A);
		rd_chk(ADDR_DARK_DIM, 8'h55);
		$display("test code registers done");
		for (int i = 0; i < 7; i++) begin
			u_lscr_host_model.wr(ADDR_SINK_EN, 8'h80 | (8'h01 << i));
			`CHK(sinks, 7'h01 << i)
			rd_chk(ADDR_SINK_EN, 8'h01 << i);
		end
		$display("test sink enables done");
		for (int l = 0; l < 4; l++) begin
			u_lscr_host_model.wr(ADDR_FADE_LAW, {6'h3F, 2'(l)});
			`CHK(law, 2'(l))
			@(posedge clk_i);
			#1;
			`CHK({fade_sq, fade_cu}, {1'(l != 0), 1'(l >= 2)})
			rd_chk(ADDR_FADE_LAW, {6'h00, 2'(l)});
		end
		$display("test fade law done");
		u_lscr_host_model.wr(8'h11, 8'hFF);
		rd_chk(8'h11, 8'h00);
		rd_chk(8'h0B, 8'h00);
		`CHK(sinks, 7'h40)
		$display("test unmapped done");
		u_lscr_host_model.wr(ADDR_OFFICE_DIM, 8'h01);
		u_lscr_host_model.wr(ADDR_DARK_MAX, 8'h7F);
		u_lscr_host_model.wr(ADDR_DARK_DIM, 8'h03);
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_i);
			{dark_level, dim_timeout, dim_en, bl_square} <= sel[k];
			repeat (2) @(posedge clk_i);
			#1;
			`CHK(bl_code, exc[k])
			`CHK(bl_ua, ua(exc[k], sel[k][0]))
		end
		$display("test level select done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		#1;
		`CHK({office_dim, dark_max, sinks, law}, 23'h0)
		@(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(ADDR_DARK_DIM, 8'h00);
		$display("test second reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
